//--- anbt_pkg.sv
// Notes on behaviour
// R1 - NOR single read samples at delay count
// R2 - Page read first word at delay count
// R3 - Later page words every interval count
// R4 - NAND read samples at delay count
// R5 - All counts multiplied by scale plus one
// R6 - Divider zero: bus clock equals functional; code drives the busy level instead
// R7 - Four chip selects, two wait inputs
// R8 - Write strobe width is off minus on
// R9 - Write cycle lasts scaled cycle length
// R10 - Read cycle lasts scaled read length
// R11 - Read strobe width is off minus on
// R12 - Half delay postpones edge half cycle
// R13 - Latch enable at its on count
// R14 - Write data valid on to cycle end
// R15 - Latch released at write off count
// R16 - Select released at write off count
// R17 - Read strobe on, select read off
// R18 - Functional clock source select fixed
// R19 - Functional clock never driven out
// R20 - Page interval held in its field
// R21 - Counts start at first cycle edge
// R22 - Software orders counts sensibly
package anbt_pkg;
  // ==========================================
  // Sizes
  localparam int CNT_W   = 5;
  localparam int SCALE_W = 2;
  localparam int TIME_W  = CNT_W + SCALE_W + 2;
  localparam int BUS_W   = 16;
  localparam int NUM_CS  = 4;
  localparam int NUM_WAIT = 2;
  localparam int PAGE_WORDS = 4;
  // ==========================================
  // Reset values
  localparam logic [BUS_W-1:0] BUS_RST = 16'h0000;
  // R18 source select code for the functional clock
  localparam logic [1:0] FCLK_SEL_CODE = 2'h0;

  typedef enum logic [2:0] {
    ANBT_NOR_READ  = 3'h0,
    ANBT_NOR_PAGE  = 3'h1,
    ANBT_NOR_WRITE = 3'h2,
    ANBT_NAND_CMD  = 3'h3,
    ANBT_NAND_ADDR = 3'h4,
    ANBT_NAND_READ = 3'h5,
    ANBT_NAND_WRITE = 3'h6
  } anbt_kind_t;

  typedef enum logic [1:0] {
    ANBT_IDLE = 2'h0,
    ANBT_RUN  = 2'h1,
    ANBT_DONE = 2'h2
  } anbt_state_t;
endpackage

//--- anbt_engine.sv
`timescale 1ns/10ps
`default_nettype none
module anbt_engine #(
  parameter int NUM_SELECTS = 4
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  // Request
  input  wire logic                          start,
  input  wire anbt_pkg::anbt_kind_t          kind,
  input  wire logic [1:0]                    cs_index,
  input  wire logic [anbt_pkg::BUS_W-1:0]    wr_data,
  output logic                               busy,
  output logic                               done,
  // Read data
  output logic [anbt_pkg::BUS_W-1:0]         rd_data,
  output logic                               rd_valid,
  // Timing fields
  input  wire logic [anbt_pkg::SCALE_W-1:0]  timing_scale_select,
  input  wire logic [1:0]                    ext_clock_divider,
  input  wire logic [anbt_pkg::CNT_W-1:0]    select_on_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    select_read_off_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    select_write_off_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    latch_enable_on_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    latch_enable_write_off_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    read_strobe_on_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    read_strobe_off_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    write_strobe_on_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    write_strobe_off_count,
  input  wire logic [anbt_pkg::CNT_W-1:0]    read_cycle_length,
  input  wire logic [anbt_pkg::CNT_W-1:0]    write_cycle_length,
  input  wire logic [anbt_pkg::CNT_W-1:0]    data_sample_delay,
  input  wire logic [anbt_pkg::CNT_W-1:0]    page_sample_interval,
  input  wire logic                          select_half_delay,
  input  wire logic                          latch_half_delay,
  input  wire logic                          read_strobe_half_delay,
  input  wire logic                          write_strobe_half_delay,
  // Flash pins
  output logic [NUM_SELECTS-1:0]             chip_select_n,
  input  wire logic [anbt_pkg::NUM_WAIT-1:0] wait_input,
  output logic                               write_strobe_n,
  output logic                               read_strobe_n,
  output logic                               byte_enable_command_latch,
  output logic                               address_valid_latch,
  output logic                               external_bus_clock,
  input  wire logic [anbt_pkg::BUS_W-1:0]    addr_data_bus_in,
  output logic [anbt_pkg::BUS_W-1:0]         addr_data_bus_out,
  output logic                               addr_data_bus_oe
);
  import anbt_pkg::*;

  // R7 four selects only
  initial begin
    if (NUM_SELECTS != NUM_CS) begin
      $error("NUM_SELECTS must be four");
    end
  end

  // ==========================================
  // Scaling
  // R5 scale by select plus one
  function automatic logic [TIME_W-1:0] scaled(
    input logic [CNT_W-1:0]   c,
    input logic [SCALE_W-1:0] s
  );
    logic [TIME_W-1:0] m;
    m = TIME_W'(s) + TIME_W'(1);
    return TIME_W'(TIME_W'(c) * m);
  endfunction

  anbt_state_t                state;
  anbt_kind_t                 cur_kind;
  logic [1:0]                 cur_cs;
  logic [TIME_W-1:0]          tick;
  logic [TIME_W-1:0]          next_sample;
  logic [1:0]                 page_word;
  logic [BUS_W-1:0]           wdata;
  logic                       cs_act;
  logic                       le_act;
  logic                       re_act;
  logic                       we_act;
  logic                       is_read;
  logic                       is_nand_wr;
  logic [TIME_W-1:0]          cyc_end;
  logic [TIME_W-1:0]          cs_off;
  logic [TIME_W-1:0]          page_ext;

  assign is_read = (cur_kind == ANBT_NOR_READ) ||
                   (cur_kind == ANBT_NOR_PAGE) ||
                   (cur_kind == ANBT_NAND_READ);
  assign is_nand_wr = (cur_kind == ANBT_NAND_CMD) ||
                      (cur_kind == ANBT_NAND_ADDR) ||
                      (cur_kind == ANBT_NAND_WRITE);
  // R3 three later address phases stretch select, strobe and cycle
  assign page_ext = (cur_kind == ANBT_NOR_PAGE) ?
    TIME_W'(scaled(page_sample_interval, timing_scale_select) * 3) :
    TIME_W'(0);
  // R9 R10 scaled cycle lengths; page reads add interval per later word
  assign cyc_end = is_read ?
    scaled(read_cycle_length, timing_scale_select) + page_ext :
    scaled(write_cycle_length, timing_scale_select);
  // R16 R17 select released at its off count
  assign cs_off = is_read ?
    scaled(select_read_off_count, timing_scale_select) + page_ext :
    scaled(select_write_off_count, timing_scale_select);

  // ==========================================
  // Sequencer
  // R21 counting from first edge of the cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= ANBT_IDLE;
      cur_kind <= ANBT_NOR_READ;
      cur_cs   <= 2'h0;
      tick     <= '0;
      wdata    <= BUS_RST;
    end else begin
      unique case (state)
        ANBT_IDLE: begin
          tick <= '0;
          if (start) begin
            state    <= ANBT_RUN;
            cur_kind <= kind;
            cur_cs   <= cs_index;
            wdata    <= wr_data;
          end
        end
        ANBT_RUN: begin
          tick <= tick + TIME_W'(1);
          if (tick + TIME_W'(1) >= cyc_end) begin
            state <= ANBT_DONE;
          end
        end
        ANBT_DONE: begin
          state <= ANBT_IDLE;
        end
        default: state <= ANBT_IDLE;
      endcase
    end
  end

  assign busy = (state != ANBT_IDLE);
  assign done = (state == ANBT_DONE);

  // ==========================================
  // Strobe windows, full-cycle resolution
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_act <= 1'b0;
      le_act <= 1'b0;
      re_act <= 1'b0;
      we_act <= 1'b0;
    end else if (state == ANBT_RUN) begin
      // R21 select on at its on count
      cs_act <= (tick >= scaled(select_on_count, timing_scale_select)) &&
                (tick < cs_off);
      // R13 R15 latch from on count to write off count
      le_act <= ((cur_kind == ANBT_NAND_CMD) ||
                 (cur_kind == ANBT_NAND_ADDR) || !is_nand_wr) &&
                (tick >= scaled(latch_enable_on_count, timing_scale_select)) &&
                (tick < scaled(latch_enable_write_off_count,
                               timing_scale_select));
      // R11 R17 read strobe off minus on wide
      re_act <= is_read &&
                (tick >= scaled(read_strobe_on_count, timing_scale_select)) &&
                (tick < scaled(read_strobe_off_count, timing_scale_select) +
                        page_ext);
      // R8 write strobe off minus on wide
      we_act <= !is_read &&
                (tick >= scaled(write_strobe_on_count, timing_scale_select)) &&
                (tick < scaled(write_strobe_off_count, timing_scale_select));
    end else begin
      cs_act <= 1'b0;
      le_act <= 1'b0;
      re_act <= 1'b0;
      we_act <= 1'b0;
    end
  end

  // ==========================================
  // Half-cycle postponement
  // R12 falling-edge copies add half a period
  logic cs_neg;
  logic le_neg;
  logic re_neg;
  logic we_neg;
  always_ff @(negedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cs_neg <= 1'b0;
      le_neg <= 1'b0;
      re_neg <= 1'b0;
      we_neg <= 1'b0;
    end else begin
      cs_neg <= cs_act;
      le_neg <= le_act;
      re_neg <= re_act;
      we_neg <= we_act;
    end
  end

  logic cs_on;
  logic we_on;
  assign cs_on = select_half_delay ? cs_neg : cs_act;
  assign we_on = write_strobe_half_delay ? we_neg : we_act;
  always_comb begin
    for (int i = 0; i < NUM_SELECTS; i++) begin
      chip_select_n[i] = !(cs_on && (cur_cs == 2'(i)));
    end
  end
  assign write_strobe_n = !we_on;
  assign read_strobe_n  = !(read_strobe_half_delay ? re_neg : re_act);
  // Command cycles use the byte-enable pin as latch
  assign byte_enable_command_latch = (cur_kind == ANBT_NAND_CMD) ?
    (latch_half_delay ? le_neg : le_act) : 1'b0;
  assign address_valid_latch = (cur_kind == ANBT_NAND_ADDR) ?
    (latch_half_delay ? le_neg : le_act) :
    ((cur_kind == ANBT_NAND_CMD) ? 1'b0 :
     !(latch_half_delay ? le_neg : le_act));

  // ==========================================
  // Write data drive
  // R14 data valid from strobe on to cycle end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_data_bus_oe  <= 1'b0;
      addr_data_bus_out <= BUS_RST;
    end else begin
      addr_data_bus_oe  <= (state == ANBT_RUN) && !is_read &&
        (tick >= scaled(write_strobe_on_count, timing_scale_select));
      addr_data_bus_out <= wdata;
    end
  end

  // ==========================================
  // Read capture
  // R1 R2 R4 first sample at scaled delay
  // R3 R20 later page words every interval
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data     <= BUS_RST;
      rd_valid    <= 1'b0;
      next_sample <= '0;
      page_word   <= 2'h0;
    end else begin
      rd_valid <= 1'b0;
      if (state == ANBT_IDLE) begin
        next_sample <= scaled(data_sample_delay, timing_scale_select);
        page_word   <= 2'h0;
      end else if (state == ANBT_RUN && is_read && tick == next_sample &&
                   (page_word == 2'h0 || cur_kind == ANBT_NOR_PAGE)) begin
        rd_data     <= addr_data_bus_in;
        rd_valid    <= 1'b1;
        page_word   <= page_word + 2'h1;
        next_sample <= (cur_kind == ANBT_NOR_PAGE && page_word != 2'h3) ?
          tick + scaled(page_sample_interval, timing_scale_select) :
          {TIME_W{1'b1}};
      end
    end
  end

  // ==========================================
  // Bus clock
  // R6 R19 divider zero passes busy level, not functional rate
  // Functional clock itself never leaves; a toggle stands in for divided rates
  logic [1:0] div_cnt;
  logic       div_clk;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt <= 2'h0;
      div_clk <= 1'b0;
    end else if (div_cnt >= ext_clock_divider) begin
      div_cnt <= 2'h0;
      div_clk <= !div_clk;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign external_bus_clock = (ext_clock_divider == 2'h0) ? busy : div_clk;

  // ==========================================
  // Checks
  // R9 write cycle length
  a_write_cycle_len: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ANBT_RUN && !is_read && tick + TIME_W'(1) >= cyc_end)
      |=> done) // R9
    else $error("write cycle overran its length");
  // R10 read cycle length
  a_read_cycle_len: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ANBT_RUN && is_read && tick < cyc_end - TIME_W'(1)) |=> !done)
    else $error("read cycle ended early"); // R10
  // R1 sample moment
  a_sample_time: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_valid && page_word == 2'h1 |->
      $past(tick) == scaled(data_sample_delay, timing_scale_select))
    else $error("first sample at wrong cycle"); // R1
  // R8 write strobe off before on count
  a_strobe_early: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ANBT_RUN &&
     tick < scaled(write_strobe_on_count, timing_scale_select)) |=> !we_act)
    else $error("write strobe too early"); // R8
  // R11 read strobe never on a write
  a_read_on_write: assert property (@(posedge core_clk) disable iff (!nrst)
    (busy && !is_read) |=> !re_act)
    else $error("read strobe on a write"); // R11
  // R14 data driven while strobe active
  a_data_with_we: assert property (@(posedge core_clk) disable iff (!nrst)
    we_act |=> addr_data_bus_oe)
    else $error("write data not driven"); // R14
  // R7 one select at a time
  a_one_select: assert property (@(posedge core_clk) disable iff (!nrst)
    $countones(~chip_select_n) <= 1)
    else $error("several selects low"); // R7
  // R21 idle leaves select, read strobe and write strobe released
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == ANBT_IDLE) [*2] |-> !cs_act && !we_act && !re_act)
    else $error("strobe active while idle"); // R21
endmodule
`default_nettype wire

//--- anbt_flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module anbt_flash_model #(
  parameter logic [15:0] WORD_BASE = 16'h5a3c
) (
  // Strobes from the controller
  input  wire logic [3:0]  chip_select_n,
  input  wire logic        read_strobe_n,
  // Data towards the controller
  output logic [15:0] bus_in
);
  import anbt_pkg::*;
  logic [15:0] last = 16'h0000;
  // ==========================================
  // Read drive
  // Released bus shows the inverse of the last word, never a held copy
  always @(chip_select_n or read_strobe_n) begin
    if (chip_select_n != 4'hf && read_strobe_n == 1'b0) begin
      bus_in = WORD_BASE ^ {12'h000, ~chip_select_n};
      last = bus_in;
    end else begin
      bus_in = ~last;
    end
  end
endmodule
`default_nettype wire

//--- async_nor_nand_bus_timing_tb.sv
`timescale 1ns/10ps
`default_nettype none
module async_nor_nand_bus_timing_tb;
  import anbt_pkg::*;
  // ==========================================
  // Stimulus and observed pins
  // ordered counts
  localparam int CS_ON = 1, LE_ON = 2, WE_ON = 3, RE_ON = 3, WE_OFF = 6;
  localparam int RE_OFF = 7, LEW_OFF = 8, CSW_OFF = 9, CSR_OFF = 9;
  localparam int DSD = 6, PI = 3, WR_LEN = 11, RD_LEN = 10;
  logic               core_clk = 1'b0;
  logic               nrst     = 1'b0;
  logic               start    = 1'b0;
  anbt_kind_t         kind     = ANBT_NOR_READ;
  logic [1:0]         cs_index = 2'h0;
  logic [15:0]        wr_data  = 16'h0000;
  logic [SCALE_W-1:0] scale    = 2'h0;
  logic [3:0]         hd       = 4'h0;
  logic               busy, done, rd_valid, we_n, re_n, cle, ale, ebc, oe;
  logic [15:0]        rd_data, bus_in, bus_out;
  logic [3:0]         cs_n;
  int fail_count = 0;
  int n_checks = 0;
  int sf, nb, nw, nr, nc, nl, fc, fw, fr, fl, fv, lv, nv, gap, oc, nd, bad;
  always #20 core_clk = ~core_clk;

  anbt_engine #(.NUM_SELECTS(4)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .start(start), .kind(kind),
    .cs_index(cs_index), .wr_data(wr_data), .busy(busy), .done(done),
    .rd_data(rd_data), .rd_valid(rd_valid), .timing_scale_select(scale),
    .ext_clock_divider(2'h0), .select_on_count(CNT_W'(CS_ON)),
    .select_read_off_count(CNT_W'(CSR_OFF)),
    .select_write_off_count(CNT_W'(CSW_OFF)),
    .latch_enable_on_count(CNT_W'(LE_ON)),
    .latch_enable_write_off_count(CNT_W'(LEW_OFF)),
    .read_strobe_on_count(CNT_W'(RE_ON)),
    .read_strobe_off_count(CNT_W'(RE_OFF)),
    .write_strobe_on_count(CNT_W'(WE_ON)),
    .write_strobe_off_count(CNT_W'(WE_OFF)),
    .read_cycle_length(CNT_W'(RD_LEN)), .write_cycle_length(CNT_W'(WR_LEN)),
    .data_sample_delay(CNT_W'(DSD)), .page_sample_interval(CNT_W'(PI)),
    .select_half_delay(hd[0]), .latch_half_delay(hd[1]),
    .read_strobe_half_delay(hd[2]), .write_strobe_half_delay(hd[3]),
    .chip_select_n(cs_n), .wait_input(2'h0), .write_strobe_n(we_n),
    .read_strobe_n(re_n), .byte_enable_command_latch(cle),
    .address_valid_latch(ale), .external_bus_clock(ebc),
    .addr_data_bus_in(bus_in), .addr_data_bus_out(bus_out),
    .addr_data_bus_oe(oe)
  );

  anbt_flash_model flash_u (
    .chip_select_n(cs_n), .read_strobe_n(re_n), .bus_in(bus_in)
  );

  // ==========================================
  // Tasks
  task automatic chk(input string what, input int exp, input int got);
    n_checks++;
    if (exp != got) begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One access; pins sampled just after each rising edge so rising-edge register outputs settle
  task automatic access(input anbt_kind_t k, input logic [1:0] ci,
                        input int s, input logic [3:0] h);
    logic [15:0] word;
    {nb, nw, nr, nc, nl, nv, gap, oc, nd, bad} = '0;
    sf = s + 1;
    word = 16'h5a3c ^ (16'h0001 << ci);
    @(posedge core_clk);
    scale <= SCALE_W'(s);
    hd <= h;
    @(posedge core_clk);
    start <= 1'b1;
    kind <= k;
    cs_index <= ci;
    wr_data <= 16'hc35a ^ {14'h0000, ci};
    @(posedge core_clk);
    start <= 1'b0;
    for (int i = 0; i < 400; i++) begin
      #1;
      if (busy !== 1'b1) break;
      // Done cycle closes the access and is not part of the timed cycle
      if (done !== 1'b1) nb++;
      if (done === 1'b1) nd++;
      if (cs_n[ci] === 1'b0) begin
        if (nc == 0) fc = i;
        nc++;
      end
      if ((cs_n | (4'h1 << ci)) !== 4'hf) oc++;
      if (we_n === 1'b0) begin
        if (nw == 0) fw = i;
        nw++;
      end
      // Written word held from strobe on until the cycle ends
      if (nw > 0 && (oe !== 1'b1 || bus_out !== wr_data)) bad++;
      if (re_n === 1'b0) begin
        if (nr == 0) fr = i;
        nr++;
      end
      if ((k == ANBT_NAND_CMD && cle === 1'b1) ||
          (k == ANBT_NAND_ADDR && ale === 1'b1)) begin
        if (nl == 0) fl = i;
        nl++;
      end
      // Divider zero: bus clock pin holds the busy level at every sample
      if (ebc !== 1'b1) bad++;
      if (rd_valid === 1'b1) begin
        if (nv == 0) fv = i;
        else if (i - lv != PI * sf) gap++;
        lv = i;
        nv++;
        if (rd_data !== word) bad++;
      end
      @(posedge core_clk);
    end
  endtask

  // ==========================================
  // Tests
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      access(ANBT_NAND_WRITE, 2'(s), s, {s[0], 3'h0});
      chk("write cycle", WR_LEN * sf, nb);
      chk("write done", 1, nd);
      chk("write strobe width", (WE_OFF - WE_ON) * sf, nw);
      chk("select to strobe", (WE_ON - CS_ON) * sf + s % 2, fw - fc);
      chk("write select width", (CSW_OFF - CS_ON) * sf, nc);
      chk("write data hold", 0, bad);
      chk("other selects", 0, oc);
      access(ANBT_NAND_READ, 2'(3 - s), s, 4'h0);
      chk("read cycle", RD_LEN * sf, nb);
      chk("read strobe width", (RE_OFF - RE_ON) * sf, nr);
      chk("select to read strobe", (RE_ON - CS_ON) * sf, fr - fc);
      chk("read select width", (CSR_OFF - CS_ON) * sf, nc);
      chk("nand sample point", (DSD - RE_ON) * sf, fv - fr);
      chk("nand words", 1, nv);
      chk("nand read data", 0, bad);
    end
    access(ANBT_NOR_READ, 2'h0, 1, 4'h0);
    chk("nor sample point", (DSD - RE_ON) * sf, fv - fr);
    chk("nor read data", 0, bad);
    access(ANBT_NOR_PAGE, 2'h1, 1, 4'h0);
    chk("page words", PAGE_WORDS, nv);
    chk("page first sample", (DSD - RE_ON) * sf, fv - fr);
    chk("page spacing", 0, gap);
    chk("page cycle", (RD_LEN + 3 * PI) * sf, nb);
    chk("page strobe width", (RE_OFF - RE_ON + 3 * PI) * sf, nr);
    chk("page read data", 0, bad);
    for (int j = 0; j < 2; j++) begin
      access(j ? ANBT_NAND_ADDR : ANBT_NAND_CMD, 2'h2, 0, 4'h0);
      chk("latch to strobe", WE_ON - LE_ON, fw - fl);
      chk("latch width", LEW_OFF - LE_ON, nl);
      chk("latch write data", 0, bad);
    end
    test_done();
  end

  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
